// file: ext_bus_timing.v
// external memory bus cycle sequencer with timing control register
//
// Contract
// - setup field 7:6 inserts 0..3 cycles
// - strobe low for width field plus one
// - hold field keeps address 0..3 cycles
// - non-muxed 16-bit move drives full address
// - non-muxed no-bank 8-bit: low byte only
// - non-muxed bank 8-bit: high byte from bank
// - muxed 16-bit: low address then data
// - muxed no-bank 8-bit: upper pins undriven
// - muxed bank 8-bit: high byte from bank
// - latch strobe high 1..4 cycles
// - latch strobe low 1..4 cycles
// - write data 1..19 cycles before strobe end
// - write data held 0..3 after strobe
// - timing settings reset to maximum
// - access adds four cycles overhead
// - config bit 4 selects non-muxed bus
`timescale 1ns/10ps
`include "ext_bus_timing_regs.vh"
module ext_bus_timing (
   // clock and reset
   input  wire        ref_clk,
   input  wire        resetn,
   // special function register port
   input  wire [7:0]  sfr_addr,
   input  wire        sfr_wr,
   input  wire [7:0]  sfr_wdata,
   output wire [7:0]  sfr_rdata,
   // configuration from other registers
   input  wire [4:0]  ext_bus_config_reg,
   input  wire [7:0]  bank_select_reg,
   // external move request
   input  wire        external_move_op,
   input  wire        op_write,
   input  wire        op_wide,
   input  wire [15:0] wide_pointer_reg,
   input  wire [7:0]  byte_pointer,
   input  wire [7:0]  op_wdata,
   output wire        op_busy,
   output reg         op_done,
   output reg  [7:0]  op_rdata,
   // external pins
   output reg  [15:8] addr_hi_o,
   output reg         addr_hi_oe,
   output reg  [7:0]  addr_lo_o,
   output reg         addr_lo_oe,
   output reg  [7:0]  data_o,
   output reg         data_oe,
   input  wire [7:0]  data_i,
   output reg         ale,
   output reg         rd_n,
   output reg         wr_n
);
   localparam S_IDLE  = 3'h0;
   localparam S_ALEH  = 3'h1;
   localparam S_ALEL  = 3'h2;
   localparam S_SETUP = 3'h3;
   localparam S_STRB  = 3'h4;
   localparam S_HOLD  = 3'h5;
   localparam S_TAIL  = 3'h6;

   reg  [7:0]  timing_r;
   reg  [2:0]  state_r;
   reg  [3:0]  cnt_r;
   reg         wr_r;
   reg         mux_r;
   reg  [7:0]  wdat_r;
   reg  [7:0]  lo_r;
   reg  [7:0]  data_s1_r;
   reg  [7:0]  data_s2_r;
   wire [1:0]  setup_sel = timing_r[`TC_SETUP_HI:`TC_SETUP_LO];
   wire [3:0]  width_sel = timing_r[`TC_WIDTH_HI:`TC_WIDTH_LO];
   wire [1:0]  hold_sel  = timing_r[`TC_HOLD_HI:`TC_HOLD_LO];
   wire [1:0]  ale_sel   = ext_bus_config_reg[`CF_ALE_HI:`CF_ALE_LO];
   wire [2:0]  mode      = ext_bus_config_reg[`CF_MODE_HI:`CF_MODE_LO];
   wire        nonmux    = ext_bus_config_reg[`CF_NONMUX_BIT];
   wire        bank      = (mode == `MODE_MUX_BANK) ||
                           (mode == `MODE_NMX_BANK);

   assign sfr_rdata = (sfr_addr == `TC_ADDR) ? timing_r : 8'h00;
   assign op_busy   = (state_r != S_IDLE);

   // timing register, comes up at maximum delays
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         timing_r <= `TC_RESET;
      end else if (sfr_wr && sfr_addr == `TC_ADDR) begin
         timing_r <= sfr_wdata;
      end
   end

   // read data pins pass two flops before sampling
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         data_s1_r <= 8'h00;
         data_s2_r <= 8'h00;
      end else begin
         data_s1_r <= data_i;
         data_s2_r <= data_s1_r;
      end
   end

   // access sequencer: latch phase, setup, strobe, hold, overhead
   always @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r    <= S_IDLE;
         cnt_r      <= 4'h0;
         wr_r       <= 1'b0;
         mux_r      <= 1'b0;
         wdat_r     <= 8'h00;
         lo_r       <= 8'h00;
         addr_hi_o  <= 8'h00;
         addr_hi_oe <= 1'b0;
         addr_lo_o  <= 8'h00;
         addr_lo_oe <= 1'b0;
         data_o     <= 8'h00;
         data_oe    <= 1'b0;
         ale        <= 1'b0;
         rd_n       <= 1'b1;
         wr_n       <= 1'b1;
         op_done    <= 1'b0;
         op_rdata   <= 8'h00;
      end else begin
         op_done <= 1'b0;
         case (state_r)
            S_IDLE: begin
               if (external_move_op) begin
                  wr_r   <= op_write;
                  mux_r  <= ~nonmux;
                  wdat_r <= op_wdata;
                  lo_r   <= op_wide ? wide_pointer_reg[7:0] : byte_pointer;
                  // upper byte: pointer, bank or left to port latch
                  if (op_wide) begin
                     addr_hi_o  <= wide_pointer_reg[15:8];
                     addr_hi_oe <= 1'b1;
                  end else if (bank) begin
                     addr_hi_o  <= bank_select_reg;
                     addr_hi_oe <= 1'b1;
                  end else begin
                     addr_hi_oe <= 1'b0;
                  end
                  if (nonmux) begin
                     addr_lo_o  <= op_wide ? wide_pointer_reg[7:0]
                                           : byte_pointer;
                     addr_lo_oe <= 1'b1;
                     data_o     <= op_wdata;
                     data_oe    <= op_write;
                     // zero setup: strobe falls with the address edge
                     if (setup_sel == 2'b00) begin
                        rd_n    <= op_write;
                        wr_n    <= ~op_write;
                        cnt_r   <= width_sel;
                        state_r <= S_STRB;
                     end else begin
                        cnt_r   <= {2'b00, setup_sel} - 4'h1;
                        state_r <= S_SETUP;
                     end
                  end else begin
                     data_o  <= op_wide ? wide_pointer_reg[7:0]
                                        : byte_pointer;
                     data_oe <= 1'b1;
                     ale     <= 1'b1;
                     cnt_r   <= {2'b00, ale_sel};
                     state_r <= S_ALEH;
                  end
               end
            end
            S_ALEH: begin
               if (cnt_r == 4'h0) begin
                  ale     <= 1'b0;
                  data_oe <= 1'b0;
                  cnt_r   <= {2'b00, ale_sel};
                  state_r <= S_ALEL;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            S_ALEL: begin
               if (cnt_r == 4'h0) begin
                  data_o  <= wdat_r;
                  data_oe <= wr_r;
                  if (setup_sel == 2'b00) begin
                     rd_n    <= wr_r;
                     wr_n    <= ~wr_r;
                     cnt_r   <= width_sel;
                     state_r <= S_STRB;
                  end else begin
                     cnt_r   <= {2'b00, setup_sel} - 4'h1;
                     state_r <= S_SETUP;
                  end
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            S_SETUP: begin
               if (cnt_r == 4'h0) begin
                  rd_n    <= wr_r;
                  wr_n    <= ~wr_r;
                  cnt_r   <= width_sel;
                  state_r <= S_STRB;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            S_STRB: begin
               if (cnt_r == 4'h0) begin
                  if (!wr_r) begin
                     op_rdata <= data_s2_r;
                  end
                  rd_n    <= 1'b1;
                  wr_n    <= 1'b1;
                  // zero hold: pins released with the strobe
                  if (hold_sel == 2'b00) begin
                     addr_hi_oe <= 1'b0;
                     addr_lo_oe <= 1'b0;
                     data_oe    <= 1'b0;
                     cnt_r      <= `OVERHEAD_CYC - 4'h1;
                     state_r    <= S_TAIL;
                  end else begin
                     cnt_r   <= {2'b00, hold_sel} - 4'h1;
                     state_r <= S_HOLD;
                  end
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            S_HOLD: begin
               if (cnt_r == 4'h0) begin
                  addr_hi_oe <= 1'b0;
                  addr_lo_oe <= 1'b0;
                  data_oe    <= 1'b0;
                  cnt_r      <= `OVERHEAD_CYC - 4'h1;
                  state_r    <= S_TAIL;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            S_TAIL: begin
               if (cnt_r == 4'h0) begin
                  op_done <= 1'b1;
                  state_r <= S_IDLE;
               end else begin
                  cnt_r <= cnt_r - 4'h1;
               end
            end
            default: begin
               state_r <= S_IDLE;
            end
         endcase
      end
   end
endmodule

// file: ext_bus_timing_checker.sv
// assertions on strobe, latch and completion timing at the pins
`timescale 1ns/10ps
module ext_bus_timing_checker (
   // clock, reset and pins
   input logic ref_clk, resetn, ale, rd_n, wr_n,
   input logic data_oe, op_busy, op_done
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   AST_ONE_STRB: assert property (rd_n || wr_n)
      else $error("strobes overlap");
   AST_WR_DATA: assert property (!wr_n |-> data_oe)
      else $error("write strobe without data");
   AST_ALE_IDLE: assert property (ale |-> rd_n && wr_n)
      else $error("latch strobe during strobe");
   AST_WR_WIDTH: assert property ($fell(wr_n) |-> ##[1:16] wr_n)
      else $error("write strobe too long");
   AST_RD_WIDTH: assert property ($fell(rd_n) |-> ##[1:16] rd_n)
      else $error("read strobe too long");
   AST_ALE_HIGH: assert property ($rose(ale) |-> ##[1:4] !ale)
      else $error("latch strobe too long");
   AST_WR_HOLD: assert property ($rose(wr_n) |-> ##[0:3] !data_oe)
      else $error("write data held too long");
   AST_BUSY: assert property (!(rd_n && wr_n) |-> op_busy)
      else $error("strobe while idle");
   AST_DONE_ONE: assert property (op_done |=> !op_done)
      else $error("done longer than a cycle");
   AST_DONE_IDLE: assert property (op_done |-> rd_n && wr_n && !ale)
      else $error("done with bus active");
endmodule
bind ext_bus_timing ext_bus_timing_checker chk_u (.ref_clk(ref_clk),
   .resetn(resetn), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
   .data_oe(data_oe), .op_busy(op_busy), .op_done(op_done));

// file: ext_bus_timing_regs.vh
// register offsets, field positions, reset values and mode codes
`ifndef EXT_BUS_TIMING_REGS_VH
`define EXT_BUS_TIMING_REGS_VH
`define TC_ADDR        8'haf
`define TC_RESET       8'hff
`define TC_SETUP_HI    7
`define TC_SETUP_LO    6
`define TC_WIDTH_HI    5
`define TC_WIDTH_LO    2
`define TC_HOLD_HI     1
`define TC_HOLD_LO     0
`define CF_NONMUX_BIT  4
`define CF_MODE_HI     4
`define CF_MODE_LO     2
`define CF_ALE_HI      1
`define CF_ALE_LO      0
`define MODE_MUX_BANK  3'h2
`define MODE_NMX_BANK  3'h6
`define OVERHEAD_CYC   4'h4
`endif

// file: ext_bus_timing_test.sv
// random bus cycles through mode codes 1-3 and 5-7 with random timing settings
`timescale 1ns/10ps
module ext_bus_timing_test;
   logic ref_clk = 0, resetn = 0, sfr_wr = 0, go = 0, wr = 0, wd = 0;
   logic clr = 0;
   logic [7:0] sfr_addr = 0, sfr_wdata = 0, bank = 0, bp = 0, wdat = 0;
   logic [7:0] sfr_rdata, rdata, data_i, adr_lo, adr_hi, data_o, lo_s;
   logic [4:0] cfg = 0;
   logic [15:0] wp = 0;
   logic [8:0] hi_s;
   logic busy, done, ale, rd_n, wr_n, ahi_oe, alo_oe, doe;
   int mismatches = 0, num_checks = 0, seed = 32'h7ebd;
   int strb, pre, post, alen, alow, cyc;
   ext_bus_timing dut_u (.ref_clk(ref_clk), .resetn(resetn),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .ext_bus_config_reg(cfg),
      .bank_select_reg(bank), .external_move_op(go), .op_write(wr),
      .op_wide(wd), .wide_pointer_reg(wp), .byte_pointer(bp),
      .op_wdata(wdat), .op_busy(busy), .op_done(done), .op_rdata(rdata),
      .addr_hi_o(adr_hi), .addr_hi_oe(ahi_oe), .addr_lo_o(adr_lo),
      .addr_lo_oe(alo_oe), .data_o(data_o), .data_oe(doe),
      .data_i(data_i), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
   ext_sram_model mem_u (.mux(!cfg[4]), .ale(ale), .rd_n(rd_n),
      .wr_n(wr_n), .addr_lo_o(adr_lo), .data_o(data_o), .data_i(data_i));
   always #5 ref_clk = ~ref_clk;
   // phase counters and address capture per access
   always @(posedge ref_clk) begin
      if (clr) {strb, pre, post, alen, alow} = 0;
      else if (!(rd_n && wr_n)) begin
         strb++;
         hi_s = ahi_oe ? {1'b1, adr_hi} : 9'h000;
         if (cfg[4]) lo_s = adr_lo;
      end else if (cfg[4] ? alo_oe : doe && !ale) begin
         if (strb == 0) pre++;
         else post++;
      end else if (alen > 0 && strb == 0 && !ale) alow++;
      if (ale && !clr) begin
         alen++;
         lo_s = data_o;
      end
   end
   task automatic chk(input string nm, input logic [15:0] e, g);
      num_checks++;
      if (e !== g) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic set_tc(input logic [7:0] v);
      sfr_addr = 8'haf;
      sfr_wdata = v;
      sfr_wr = 1;
      @(posedge ref_clk) #1 sfr_wr = 0;
      chk("timing readback", v, sfr_rdata);
   endtask
   task automatic op(input logic w, output int c);
      int n;
      clr = 1;
      wr = w;
      @(posedge ref_clk) #1 clr = 0;
      go = 1;
      @(posedge ref_clk) #1 go = 0;
      for (n = 0; n < 300 && done !== 1'b1; n++) @(posedge ref_clk) #1;
      c = n;
      if (n == 300) begin
         mismatches++;
         report_and_stop;
      end
   endtask
   // access length: setup, strobe, hold, four overhead, latch phases
   function automatic int exp_len(input logic [7:0] t, input logic [4:0] c);
      return t[7:6] + t[5:2] + t[1:0] + 5 + (c[4] ? 0 : 2 * (c[1:0] + 1));
   endfunction
   function automatic logic [8:0] exp_hi(input logic [2:0] m);
      if (wd) return {1'b1, wp[15:8]};
      return (m[1:0] == 2'b10) ? {1'b1, bank} : 9'h000;
   endfunction
   initial begin
      logic [7:0] tc;
      logic [2:0] m;
      repeat (6) @(posedge ref_clk);
      #1 resetn = 1;
      sfr_addr = 8'haf;
      @(posedge ref_clk) #1 chk("timing reset", 8'hff, sfr_rdata);
      sfr_addr = 8'hae;
      @(posedge ref_clk) #1 chk("unmapped", 8'h00, sfr_rdata);
      for (int i = 0; i < 60; i++) begin
         tc = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : $random(seed);
         m = (i % 6) + ((i % 6) > 2 ? 2 : 1);
         cfg = {m, 2'($random(seed))};
         bank = $random(seed);
         wp = $random(seed);
         bp = $random(seed);
         wdat = $random(seed);
         wd = i[1];
         set_tc(tc);
         op(1, cyc);
         chk("access cycles", exp_len(tc, cfg), cyc);
         chk("strobe width", tc[5:2] + 1, strb);
         chk("high address", exp_hi(m), hi_s);
         chk("low address", wd ? wp[7:0] : bp, lo_s);
         chk("setup", tc[7:6], pre);
         chk("hold", tc[1:0], post);
         if (m[2]) chk("latch unused", 0, alen);
         else begin
            chk("latch high", cfg[1:0] + 1, alen);
            chk("latch low", cfg[1:0] + 1, alow);
         end
         // reads need three strobe cycles for the pin synchroniser
         set_tc(tc | 8'h08);
         op(0, cyc);
         chk("read data", wdat, rdata);
      end
      // reset in mid-run brings the maximum delays back
      resetn = 0;
      #1 chk("timing after reset", 8'hff, sfr_rdata);
      chk("strobes after reset", 2'b11, {rd_n, wr_n});
      @(posedge ref_clk) #1 resetn = 1;
      op(1, cyc);
      chk("default access", exp_len(8'hff, cfg), cyc);
      report_and_stop;
   end
endmodule

// file: ext_sram_model.sv
// byte memory with transparent address latch on the shared pins
`timescale 1ns/10ps
module ext_sram_model (
   // bus pins
   input  logic       mux, ale, rd_n, wr_n,
   input  logic [7:0] addr_lo_o, data_o,
   output logic [7:0] data_i
);
   logic [7:0] mem [0:255];
   logic [7:0] lat, last = 8'h00;
   wire  [7:0] a = mux ? lat : addr_lo_o;
   // latch follows pins while ale high and holds once it falls
   always @* if (ale) lat = data_o;
   // store on write strobe end, drive only while read strobe low
   always @(posedge wr_n) mem[a] <= data_o;
   always @(posedge rd_n) last <= mem[a];
   assign data_i = rd_n ? ~last : mem[a]; // released pins show inverse
endmodule
